//--- test/qaas_host.sv
`default_nettype none
module qaas_host (
  input  wire logic                run,
  input  wire qaas_pkg::qaas_cfg_s cfg,
  input  wire logic                bclk_w,
  input  wire logic                fs_w,
  input  wire logic                data_w,
  output var  logic                host_bclk,
  output var  logic                host_fs,
  output var  logic [127:0]        frm,
  output var  int                  nfr
);
  timeunit 1ns;
  timeprecision 100ps;
  import qaas_pkg::*;
  int           cnt = 0;
  int           idx = 0;
  int           f;
  logic         i2s;
  logic         pcm;
  logic         prev = 1'b0;
  logic [127:0] cap = '0;
  assign i2s = cfg.fmt == QAAS_FMT_I2S;
  assign pcm = cfg.fmt inside {QAAS_FMT_PCMA, QAAS_FMT_PCMB, QAAS_FMT_SLOT};
  assign f   = cfg.tdm ? 128 : 64;
  // The bit clock rests low between bursts; sync changes after a fall.
  initial begin
    host_bclk = 1'b0;
    host_fs = 1'b0;
    frm = '0;
    nfr = 0;
    #13.7;
    forever begin
      wait (run);
      host_bclk = 1'b1;
      #40;
      host_bclk = 1'b0;
      host_fs = pcm ? (cnt == 0) : ((cnt < f / 2) ^ i2s);
      cnt = (cnt + 1) % f;
      #40;
    end
  end
  // Index 0 is the first rising edge after the opening sync edge.
  always @(posedge bclk_w) begin
    if (fs_w !== prev && fs_w === !i2s) begin
      frm = cap;
      nfr = nfr + 1;
      idx = 0;
      cap = '0;
    end
    if (idx < 128) cap[idx] = data_w;
    idx = idx + 1;
    prev = fs_w;
  end
endmodule
`default_nettype wire

//--- test/tb_quad_adc_audio_serial_port.sv
`default_nettype none
module tb_quad_adc_audio_serial_port;
  timeunit 1ns;
  timeprecision 100ps;
  import qaas_pkg::*;
  logic             clock;
  logic             rst;
  logic             sample_valid;
  logic             run;
  logic             last_d = 1'b0;
  qaas_cfg_s        cfg_in;
  logic [3:0][31:0] words;
  logic             sample_ready;
  logic             bit_clk_o;
  logic             bit_clk_oe;
  logic             frame_sync_o;
  logic             frame_sync_oe;
  logic             dout;
  logic             dout_oe;
  logic             host_bclk;
  logic             host_fs;
  logic             bclk_w;
  logic             fs_w;
  logic             data_w;
  logic [127:0]     frm;
  int               nfr;
  int               fail_count;
  int               n_tests;

  qaas_port qaas_port_inst (
    .clock(clock), .rst(rst), .cfg_in(cfg_in),
    .sample_valid(sample_valid), .sample_word(words),
    .sample_ready(sample_ready), .bit_clk(bclk_w),
    .bit_clk_o(bit_clk_o), .bit_clk_oe(bit_clk_oe),
    .frame_sync_i(fs_w), .frame_sync_o(frame_sync_o),
    .frame_sync_oe(frame_sync_oe), .serial_sample_out_o(dout),
    .serial_sample_out_oe(dout_oe)
  );
  qaas_host qaas_host_inst (
    .run(run), .cfg(cfg_in), .bclk_w(bclk_w), .fs_w(fs_w),
    .data_w(data_w), .host_bclk(host_bclk), .host_fs(host_fs),
    .frm(frm), .nfr(nfr)
  );
  assign bclk_w = bit_clk_oe ? bit_clk_o : host_bclk;
  assign fs_w   = frame_sync_oe ? frame_sync_o : host_fs;
  assign data_w = dout_oe ? dout : ~last_d;
  always @(posedge bclk_w) if (dout_oe) last_d <= dout;

  function automatic logic [127:0] expect_frame(qaas_cfg_s c);
    logic [127:0] e;
    int           s;
    int           f;
    int           wl;
    int           st;
    int           ch;
    e = '0;
    s = c.tdm ? 4 : 2;
    f = 32 * s;
    wl = c.wlen == QAAS_WLEN_32 ? 32 : 16 + 4 * int'(c.wlen);
    for (int k = 0; k < s; k++) begin
      case (c.fmt)
        QAAS_FMT_RJ:   st = 32 * k + 32 - wl;
        QAAS_FMT_LJ:   st = 32 * k;
        QAAS_FMT_I2S:  st = 32 * k + 1;
        QAAS_FMT_PCMA: st = 1 + k * wl;
        QAAS_FMT_PCMB: st = k * wl;
        default:       st = int'(c.offset) + k * wl;
      endcase
      ch = (c.tdm && c.fmt <= QAAS_FMT_I2S && (k == 1 || k == 2)) ? 3 - k : k;
      if (c.remap) ch = int'(c.slot_map[k]);
      for (int j = 0; j < wl; j++) e[(st + j) % f] = words[ch][31 - j];
    end
    return e;
  endfunction

  task automatic check_frame(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_ready;
    repeat (400) begin
      if (sample_ready === 1'b1) break;
      @(posedge clock);
      #1;
    end
  endtask

  task automatic run_case(input qaas_fmt_e fm, input logic td,
                          input qaas_wlen_e wl, input qaas_idx_t off,
                          input logic [7:0] map, input logic ms);
    int n;
    @(posedge clock);
    #1;
    cfg_in = '{fmt: fm, tdm: td, wlen: wl, master: ms, offset: off,
               remap: map != 8'he4, slot_map: map, share: 1'b0};
    run = !ms;
    @(posedge clock);
    #1;
    sample_valid = 1'b1;
    wait_ready();
    @(posedge clock);
    #1;
    sample_valid = 1'b0;
    wait_ready();
    check_bit(sample_ready, 1'b1);
    n = nfr;
    repeat (20000) begin
      if (nfr >= n + 3) break;
      @(posedge clock);
    end
    check_bit(nfr >= n + 3, 1'b1);
    check_frame(frm, expect_frame(cfg_in));
  endtask

  task automatic t_lj;
    run_case(QAAS_FMT_LJ, 1'b0, QAAS_WLEN_24, 7'h00, 8'he4, 1'b0);
  endtask
  task automatic t_i2s;
    run_case(QAAS_FMT_I2S, 1'b0, QAAS_WLEN_32, 7'h00, 8'he4, 1'b0);
  endtask
  task automatic t_rj;
    run_case(QAAS_FMT_RJ, 1'b0, QAAS_WLEN_20, 7'h00, 8'he4, 1'b0);
  endtask
  task automatic t_pcma;
    run_case(QAAS_FMT_PCMA, 1'b0, QAAS_WLEN_16, 7'h00, 8'he4, 1'b0);
  endtask
  task automatic t_pcmb;
    run_case(QAAS_FMT_PCMB, 1'b0, QAAS_WLEN_32, 7'h00, 8'he4, 1'b0);
  endtask
  task automatic t_slot;
    run_case(QAAS_FMT_SLOT, 1'b0, QAAS_WLEN_24, 7'h05, 8'h01, 1'b0);
  endtask
  task automatic t_tdm_lj;
    run_case(QAAS_FMT_LJ, 1'b1, QAAS_WLEN_24, 7'h00, 8'he4, 1'b0);
  endtask
  task automatic t_tdm_rj;
    run_case(QAAS_FMT_RJ, 1'b1, QAAS_WLEN_16, 7'h00, 8'he4, 1'b0);
  endtask
  task automatic t_tdm_i2s;
    run_case(QAAS_FMT_I2S, 1'b1, QAAS_WLEN_24, 7'h00, 8'he4, 1'b0);
  endtask
  task automatic t_tdm_pcma;
    run_case(QAAS_FMT_PCMA, 1'b1, QAAS_WLEN_24, 7'h00, 8'he4, 1'b0);
  endtask
  task automatic t_tdm_pcmb;
    run_case(QAAS_FMT_PCMB, 1'b1, QAAS_WLEN_32, 7'h00, 8'he4, 1'b0);
  endtask
  task automatic t_tdm_off;
    run_case(QAAS_FMT_SLOT, 1'b1, QAAS_WLEN_24, 7'h08, 8'h50, 1'b0);
  endtask
  task automatic t_master;
    run_case(QAAS_FMT_LJ, 1'b0, QAAS_WLEN_24, 7'h00, 8'he4, 1'b1);
    check_bit(bit_clk_oe, 1'b1);
    check_bit(frame_sync_oe, 1'b1);
  endtask

  task automatic stop_test;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    #700000;
    fail_count++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    sample_valid = 1'b0;
    run = 1'b0;
    cfg_in = QAAS_CFG_RST;
    words = {32'h1357_9BDF, 32'hF0E1_D2C3, 32'h8421_4812, 32'hA5C3_3C5A};
    fail_count = 0;
    n_tests = 0;
    repeat (16) @(posedge clock);
    #1;
    rst = 1'b0;
    @(posedge clock);
    #1;
    check_bit(bit_clk_oe, 1'b0);
    check_bit(frame_sync_oe, 1'b0);
    t_lj();
    t_i2s();
    t_rj();
    t_pcma();
    t_pcmb();
    t_slot();
    t_tdm_lj();
    t_tdm_rj();
    t_tdm_i2s();
    t_tdm_pcma();
    t_tdm_pcmb();
    t_tdm_off();
    t_master();
    stop_test();
  end
endmodule
`default_nettype wire

//--- verilog/qaas_clkdiv.sv
`default_nettype none
module qaas_clkdiv #(
  parameter int unsigned HALF_CYC = 5
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic en,
  output var  logic clk_o
);
  localparam int unsigned CW = $clog2(HALF_CYC + 1);
  logic [CW-1:0] cnt_q;

  if (HALF_CYC < 2 || HALF_CYC > 1000) begin : g_chk
    $error("qaas_clkdiv: HALF_CYC must lie in 2..1000");
  end

  // Stopped and low whenever the port is slave.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      clk_o <= 1'b0;
    end else if (!en) begin
      cnt_q <= '0;
      clk_o <= 1'b0;
    end else if (cnt_q == CW'(HALF_CYC - 1)) begin
      cnt_q <= '0;
      clk_o <= ~clk_o;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  half_period_a: assert property (@(posedge clock) disable iff (rst)
    (en && $changed(clk_o)) |=> (!en || $stable(clk_o)))
    else $error("bit clock half period too short");
  idle_low_a: assert property (@(posedge clock) disable iff (rst)
    !en |=> !clk_o)
    else $error("bit clock runs while slave");
endmodule
`default_nettype wire

//--- verilog/qaas_pkg.sv
`default_nettype none
package qaas_pkg;
  localparam int unsigned QAAS_BCLK_HALF = 5;
  typedef logic [6:0] qaas_idx_t;
  localparam qaas_idx_t  QAAS_HALF_STEREO = 7'h20;
  localparam qaas_idx_t  QAAS_HALF_TDM    = 7'h40;
  localparam qaas_idx_t  QAAS_IDX_RESYNC  = 7'h02;
  localparam qaas_idx_t  QAAS_PCMA_BASE   = 7'h01;
  localparam qaas_idx_t  QAAS_PCMB_BASE   = 7'h00;
  localparam logic [4:0] QAAS_I2S_LEAD    = 5'h01;
  localparam logic [5:0] QAAS_SLOT_BITS   = 6'h20;
  localparam logic [5:0] QAAS_WL16        = 6'h10;
  localparam logic [5:0] QAAS_WL20        = 6'h14;
  localparam logic [5:0] QAAS_WL24        = 6'h18;
  localparam logic [5:0] QAAS_WL32        = 6'h20;
  typedef enum logic [2:0] {
    QAAS_FMT_RJ   = 3'h0,
    QAAS_FMT_LJ   = 3'h1,
    QAAS_FMT_I2S  = 3'h2,
    QAAS_FMT_PCMA = 3'h3,
    QAAS_FMT_PCMB = 3'h4,
    QAAS_FMT_SLOT = 3'h5
  } qaas_fmt_e;
  typedef enum logic [1:0] {
    QAAS_WLEN_16 = 2'h0,
    QAAS_WLEN_20 = 2'h1,
    QAAS_WLEN_24 = 2'h2,
    QAAS_WLEN_32 = 2'h3
  } qaas_wlen_e;
  typedef struct packed {
    qaas_fmt_e       fmt;
    logic            tdm;
    qaas_wlen_e      wlen;
    logic            master;
    qaas_idx_t       offset;
    logic            remap;
    logic [3:0][1:0] slot_map;
    logic            share;
  } qaas_cfg_s;
  typedef struct packed {
    qaas_cfg_s        cfg;
    logic [3:0][31:0] word;
  } qaas_xfer_s;
  localparam qaas_cfg_s QAAS_CFG_RST = '{
    fmt:      QAAS_FMT_LJ,
    tdm:      1'b0,
    wlen:     QAAS_WLEN_24,
    master:   1'b0,
    offset:   7'h00,
    remap:    1'b0,
    slot_map: 8'he4,
    share:    1'b0
  };
endpackage
`default_nettype wire

//--- verilog/qaas_port.sv
`default_nettype none
module qaas_port #(
  parameter int unsigned BCLK_HALF_CYC = qaas_pkg::QAAS_BCLK_HALF
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire qaas_pkg::qaas_cfg_s cfg_in,
  input  wire logic                sample_valid,
  input  wire logic [3:0][31:0]    sample_word,
  output var  logic                sample_ready,
  input  wire logic                bit_clk,
  output var  logic                bit_clk_o,
  output var  logic                bit_clk_oe,
  input  wire logic                frame_sync_i,
  output var  logic                frame_sync_o,
  output var  logic                frame_sync_oe,
  output var  logic                serial_sample_out_o,
  output var  logic                serial_sample_out_oe
);
  import qaas_pkg::*;

  // System clock side.
  qaas_cfg_s  cfg_q;
  qaas_xfer_s hold_q;
  logic       req_q;
  logic       ack_s;
  logic       ready_q;
  logic       m_oe_q;
  logic       accept;

  // Bit clock side.
  qaas_xfer_s  lk_q;
  qaas_cfg_s   c;
  logic        req_s;
  logic        ack_q;
  logic        fs_s_q;
  logic        fs_p_q;
  qaas_idx_t   bit_q;
  logic [31:0] sh_q;
  logic [5:0]  left_q;
  logic [1:0]  slot_q;
  logic        run_q;
  logic        sdo_q;
  logic        sdo_oe_q;
  logic        fs_o_q;

  logic        fmt_i2s;
  logic        fmt_lj;
  logic        fmt_rj;
  logic        pcm;
  logic        start_seen;
  logic [5:0]  wl;
  logic [5:0]  rj_lead;
  logic [4:0]  lead;
  qaas_idx_t   half;
  qaas_idx_t   last_idx;
  qaas_idx_t   base;
  logic [1:0]  last_slot;
  logic        jhit;
  logic        phit;
  logic        chain;
  logic        load;
  logic [1:0]  ld_slot;
  logic [1:0]  ld_ch;
  logic [31:0] cur_word;
  logic        rj_armed_q;

  assign sample_ready         = ready_q;
  assign bit_clk_oe           = m_oe_q;
  assign frame_sync_oe        = m_oe_q;
  assign frame_sync_o         = fs_o_q;
  assign serial_sample_out_o  = sdo_q;
  assign serial_sample_out_oe = sdo_oe_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_q  <= QAAS_CFG_RST;
      m_oe_q <= 1'b0;
    end else begin
      cfg_q  <= cfg_in;
      m_oe_q <= cfg_q.master;
    end
  end

  // Four words and the settings travel together by a toggle handshake;
  // hold_q stays put until the bit clock side has taken it.
  assign accept = sample_valid & ready_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_q  <= '{cfg: QAAS_CFG_RST, word: '0};
      req_q   <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      if (accept) begin
        hold_q <= '{cfg: cfg_q, word: sample_word};
        req_q  <= ~req_q;
      end
      ready_q <= ~accept & (req_q == ack_s);
    end
  end

  qaas_sync2 u_ack_sync (
    .clock (clock),
    .rst   (rst),
    .d     (ack_q),
    .q     (ack_s)
  );

  qaas_sync2 u_req_sync (
    .clock (bit_clk),
    .rst   (rst),
    .d     (req_q),
    .q     (req_s)
  );

  qaas_clkdiv #(
    .HALF_CYC (BCLK_HALF_CYC)
  ) u_div (
    .clock (clock),
    .rst   (rst),
    .en    (m_oe_q),
    .clk_o (bit_clk_o)
  );

  always_ff @(posedge bit_clk or posedge rst) begin
    if (rst) begin
      lk_q  <= '{cfg: QAAS_CFG_RST, word: '0};
      ack_q <= 1'b0;
    end else if (req_s != ack_q) begin
      lk_q  <= hold_q;
      ack_q <= req_s;
    end
  end

  // Sync is taken on the rising bit clock edge, like the data at the host.
  always_ff @(posedge bit_clk or posedge rst) begin
    if (rst) begin
      fs_s_q <= 1'b0;
      fs_p_q <= 1'b0;
    end else begin
      fs_s_q <= frame_sync_i;
      fs_p_q <= fs_s_q;
    end
  end

  assign c       = lk_q.cfg;
  assign fmt_i2s = (c.fmt == QAAS_FMT_I2S);
  assign fmt_lj  = (c.fmt == QAAS_FMT_LJ);
  assign fmt_rj  = (c.fmt == QAAS_FMT_RJ);
  assign pcm     = (c.fmt == QAAS_FMT_PCMA) || (c.fmt == QAAS_FMT_PCMB) ||
                   (c.fmt == QAAS_FMT_SLOT);

  always_comb begin
    case (c.wlen)
      QAAS_WLEN_16: wl = QAAS_WL16;
      QAAS_WLEN_20: wl = QAAS_WL20;
      QAAS_WLEN_24: wl = QAAS_WL24;
      default:      wl = QAAS_WL32;
    endcase
  end

  // The frame starts at the sync edge that opens the first channel.
  assign start_seen = fmt_i2s ? (fs_p_q & ~fs_s_q)
                              : (fs_s_q & ~fs_p_q);
  assign half      = c.tdm ? QAAS_HALF_TDM : QAAS_HALF_STEREO;
  assign last_idx  = half + half - 7'h01;
  assign last_slot = c.tdm ? 2'h3 : 2'h1;

  // bit_q is the index of the next rising edge within the frame; index 0
  // is the first rising edge after the opening sync edge.
  always_ff @(posedge bit_clk or posedge rst) begin
    if (rst) begin
      bit_q <= '0;
    end else if (start_seen) begin
      bit_q <= QAAS_IDX_RESYNC;
    end else if (bit_q == last_idx) begin
      bit_q <= '0;
    end else begin
      bit_q <= bit_q + 7'h01;
    end
  end

  assign rj_lead = QAAS_SLOT_BITS - wl;
  assign lead    = fmt_rj  ? rj_lead[4:0] :
                   fmt_i2s ? QAAS_I2S_LEAD : 5'h00;
  assign base    = (c.fmt == QAAS_FMT_PCMA) ? QAAS_PCMA_BASE :
                   (c.fmt == QAAS_FMT_PCMB) ? QAAS_PCMB_BASE :
                   c.offset;

  // Justified formats start a word at a fixed place in every 32-bit slot;
  // PCM formats start at base and then chain words without a gap.
  assign jhit  = !pcm && (bit_q[4:0] == lead);
  assign phit  = pcm && (bit_q == base);
  assign chain = pcm && run_q && (left_q == 6'h00) &&
                 (slot_q != last_slot);
  assign load  = jhit | phit | chain;

  assign ld_slot = jhit ? bit_q[6:5] : phit ? 2'h0 : slot_q + 2'h1;
  // Remapping lets several slots carry the same channel or swaps them.
  assign ld_ch   = c.remap ? c.slot_map[ld_slot] :
                   (c.tdm && !pcm) ? {ld_slot[0], ld_slot[1]} :
                   ld_slot;
  assign cur_word = lk_q.word[ld_ch];

  // Data moves on the falling edge so it is settled at the rising one.
  always_ff @(negedge bit_clk or posedge rst) begin
    if (rst) begin
      sh_q     <= '0;
      left_q   <= '0;
      slot_q   <= '0;
      run_q    <= 1'b0;
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (load) begin
      sh_q     <= {cur_word[30:0], 1'b0};
      sdo_q    <= cur_word[31];
      left_q   <= wl - 6'h01;
      slot_q   <= ld_slot;
      run_q    <= 1'b1;
      sdo_oe_q <= 1'b1;
    end else if (left_q != 6'h00) begin
      sh_q     <= {sh_q[30:0], 1'b0};
      sdo_q    <= sh_q[31];
      left_q   <= left_q - 6'h01;
      sdo_oe_q <= 1'b1;
    end else begin
      sdo_q    <= 1'b0;
      sdo_oe_q <= ~c.share;
      run_q    <= 1'b0;
    end
  end

  // Sync produced for master use; it only reaches the pin while master.
  always_ff @(negedge bit_clk or posedge rst) begin
    if (rst) begin
      fs_o_q <= 1'b0;
    end else if (pcm) begin
      fs_o_q <= (bit_q == 7'h00);
    end else begin
      fs_o_q <= (bit_q < half) ^ fmt_i2s;
    end
  end

  // Marks a word in flight that was started with right-justified timing,
  // so that a settings change in mid-frame is not judged by the old word.
  always_ff @(negedge bit_clk or posedge rst) begin
    if (rst) begin
      rj_armed_q <= 1'b0;
    end else if (load) begin
      rj_armed_q <= fmt_rj;
    end
  end

  resync_idx_a: assert property (@(posedge bit_clk) disable iff (rst)
    start_seen |=> (bit_q == 7'h02))
    else $error("bit index not realigned to sync edge");

  lj_msb_a: assert property (@(negedge bit_clk) disable iff (rst)
    (fmt_lj && bit_q == 7'h00) |=> (sdo_q == $past(cur_word[31])))
    else $error("left-justified MSB not on first edge");

  i2s_delay_a: assert property (@(negedge bit_clk) disable iff (rst)
    (fmt_i2s && bit_q == 7'h01) |=>
      (run_q && slot_q == 2'h0 && left_q == $past(wl) - 6'h01))
    else $error("I2S word not started one bit late");

  rj_lsb_a: assert property (@(negedge bit_clk) disable iff (rst)
    (fmt_rj && rj_armed_q && bit_q[4:0] == 5'h1f) |=>
      (run_q && left_q == 6'h00))
    else $error("right-justified LSB not on last edge");

  word_len_a: assert property (@(negedge bit_clk) disable iff (rst)
    load |=> (left_q == $past(wl) - 6'h01))
    else $error("word length not taken from setting");

  pcm_gapless_a: assert property (@(negedge bit_clk) disable iff (rst)
    (pcm && run_q && left_q == 6'h01 && slot_q != last_slot)
      |=> (load && ld_slot == $past(slot_q) + 2'h1))
    else $error("gap between PCM words");

  idle_low_a: assert property (@(negedge bit_clk) disable iff (rst)
    (!load && left_q == 6'h00) |=>
      (!sdo_q && sdo_oe_q == !$past(c.share)))
    else $error("unused bit not low or not released");

  pcm_pulse_a: assert property (@(negedge bit_clk) disable iff (rst)
    (pcm && fs_o_q) |=> !fs_o_q)
    else $error("PCM sync pulse longer than one bit");

  ready_drop_a: assert property (@(posedge clock) disable iff (rst)
    accept |=> !sample_ready ##1 !sample_ready)
    else $error("new words taken before handover");

  slave_oe_a: assert property (@(posedge clock) disable iff (rst)
    !cfg_q.master |=> (!bit_clk_oe && !frame_sync_oe))
    else $error("clock pins driven while slave");
endmodule
`default_nettype wire

//--- verilog/qaas_sync2.sv
`default_nettype none
module qaas_sync2 (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic d,
  output var  logic q
);
  logic meta_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire
